// [bench/cft_chk.sv]
// assertions on the ports of the frame timing core
// assumes one clock domain and a low active reset
`timescale 1ns/10ps
module cft_chk(
	input wire i_clk,
	input wire i_resetn,
	input wire i_module_on_bit,
	input wire [3:0] i_word_length_field,
	input wire [3:0] i_frame_word_field,
	input wire [1:0] i_sync_type_field,
	input wire i_sync_direction_bit,
	input wire [11:0] i_bit_rate_divisor,
	input wire i_bit_clock_direction_bit,
	input wire o_serial_bit_clock,
	input wire o_serial_bit_clock_oe,
	input wire o_frame_sync_pin,
	input wire o_frame_sync_pin_oe,
	input wire o_serial_out_pin_oe,
	input wire o_rx_valid,
	input wire o_frame_active
);
reg [10:0] lo_reg;
wire d1 = i_bit_rate_divisor == 12'h001;
wire m1 = d1 && i_module_on_bit && !i_sync_direction_bit &&
	!i_bit_clock_direction_bit;
wire [10:0] fl = ({7'h00, i_word_length_field} + 11'h001) *
	({7'h00, i_frame_word_field} + 11'h001) * 11'h004;
// cycles spent low since the last sync pulse
always @(posedge i_clk or negedge i_resetn)
	if (!i_resetn)
		lo_reg <= 11'h000;
	else if (o_frame_sync_pin || !i_module_on_bit)
		lo_reg <= 11'h000;
	else
		lo_reg <= lo_reg + 11'h001;
default clocking @(posedge i_clk); endclocking
default disable iff (!i_resetn);
sequence s_d1;
	d1 ##1 d1 ##1 d1;
endsequence
// skips the first pulse after enable, which may be cut short
sequence s_rise;
	$rose(o_frame_sync_pin) && m1 && lo_reg > 11'h004;
endsequence
property p_pin_off;
	!i_module_on_bit |-> !o_frame_sync_pin_oe && !o_serial_out_pin_oe;
endproperty
a_pin_off: assert property (p_pin_off) else $error("pin on while off");
property p_fs_dir;
	i_module_on_bit |-> o_frame_sync_pin_oe == !i_sync_direction_bit;
endproperty
a_fs_dir: assert property (p_fs_dir) else $error("sync oe wrong");
property p_slave;
	i_sync_direction_bit && $past(i_sync_direction_bit) |-> !o_frame_sync_pin;
endproperty
a_slave: assert property (p_slave) else $error("slave drives sync");
property p_sck_oe;
	o_serial_bit_clock_oe == (!i_bit_clock_direction_bit &&
		i_bit_rate_divisor != 12'h000);
endproperty
a_sck_oe: assert property (p_sck_oe) else $error("clock oe wrong");
property p_off;
	!i_module_on_bit && !$past(i_module_on_bit) |->
		!o_frame_sync_pin && !o_frame_active && !o_rx_valid;
endproperty
a_off: assert property (p_off) else $error("active while off");
property p_sck;
	$rose(o_serial_bit_clock) ##0 s_d1 |->
		!o_serial_bit_clock && $past(o_serial_bit_clock);
endproperty
a_sck: assert property (p_sck) else $error("clock period wrong");
property p_pulse;
	s_rise ##0 i_sync_type_field == 2'h0 |->
		(o_frame_sync_pin [*4] ##1 !o_frame_sync_pin) or
		(##[0:4] !i_module_on_bit);
endproperty
a_pulse: assert property (p_pulse) else $error("pulse width wrong");
property p_frame;
	s_rise ##0 i_sync_type_field == 2'h0 |-> lo_reg == fl - 11'h004;
endproperty
a_frame: assert property (p_frame) else $error("frame wrong");
property p_i2s;
	s_rise ##0 i_sync_type_field == 2'h1 |-> lo_reg == fl >> 1;
endproperty
a_i2s: assert property (p_i2s) else $error("duty wrong");
property p_ac;
	s_rise ##0 i_sync_type_field[1] |-> lo_reg == 11'h3c0;
endproperty
a_ac: assert property (p_ac) else $error("link low wrong");
endmodule
bind converter_serial_frame_timing cft_chk chk(.*);

// [bench/codec_model.sv]
// far side codec: optional bit clock, 8 bit frames of sync and data
// assumes i_bclk is the port's own bit clock when it is master of it
`timescale 1ns/10ps
module codec_model(
	input wire i_clk,
	input wire i_ext,
	input wire i_slave,
	input wire i_bclk,
	output reg o_sck = 1'b0,
	output reg o_fs = 1'b0,
	output reg o_sdi = 1'b0
);
reg [2:0] div_reg = 3'h0;
reg [2:0] bit_reg = 3'h0;
// clock of 10 cycles, still when not supplied
always @(posedge i_clk)
	if (!i_ext)
	begin
		div_reg <= 3'h0;
		o_sck <= 1'b0;
	end
	else if (div_reg == 3'h4)
	begin
		div_reg <= 3'h0;
		o_sck <= ~o_sck;
	end
	else
		div_reg <= div_reg + 3'h1;
// stray pulse at bit 2 lands inside a busy frame
always @(posedge i_bclk)
begin
	bit_reg <= bit_reg + 3'h1;
	o_fs <= i_slave ? (bit_reg == 3'h7 || bit_reg == 3'h2) : ~o_fs;
	o_sdi <= ~o_sdi;
end
endmodule

// [bench/tb.sv]
// testbench of the frame timing core with a codec model
// assumes the checker is bound by its own file
`timescale 1ns/10ps
module tb;
reg i_clk, i_resetn, i_module_on_bit, i_sync_direction_bit;
reg i_bit_clock_direction_bit, i_tx_valid, m_ext, m_slv, pf, ps, po;
reg [3:0] i_word_length_field, i_frame_word_field;
reg [1:0] i_sync_type_field;
reg [11:0] i_bit_rate_divisor;
reg [15:0] i_tx_data;
reg [11:0] cfg [0:6];
wire o_serial_bit_clock, o_serial_bit_clock_oe, o_frame_sync_pin;
wire o_frame_sync_pin_oe, o_serial_out_pin, o_serial_out_pin_oe;
wire o_tx_ready, o_rx_valid, o_frame_active, m_sck, m_fs, i_serial_in_pin;
wire [15:0] o_rx_data;
wire i_serial_bit_clock = o_serial_bit_clock_oe ? o_serial_bit_clock : m_sck;
wire i_frame_sync_pin = o_frame_sync_pin_oe ? o_frame_sync_pin : m_fs;
int error_cnt, comparisons, nfs, nrx, nsck, ntx, nso, cycles, i, w;
converter_serial_frame_timing DUT(.*);
codec_model partner(.i_clk(i_clk), .i_ext(m_ext), .i_slave(m_slv),
	.i_bclk(i_serial_bit_clock), .o_sck(m_sck), .o_fs(m_fs),
	.o_sdi(i_serial_in_pin));
initial
begin
	i_clk = 1'b0;
	forever #4 i_clk = ~i_clk;
end
always @(posedge i_clk)
begin
	pf <= o_frame_sync_pin;
	ps <= o_serial_bit_clock;
	po <= o_serial_out_pin;
	if (o_serial_out_pin && !po) nso <= nso + 1;
	if (o_frame_sync_pin && !pf) nfs <= nfs + 1;
	if (o_serial_bit_clock !== ps) nsck <= nsck + 1;
	if (o_rx_valid) nrx <= nrx + 1;
	if (i_tx_valid && o_tx_ready) ntx <= ntx + 1;
	cycles <= cycles + 1;
	if (cycles == 30000)
	begin
		error_cnt++;
		finish_test;
	end
end
task chk(input logic [15:0] seen, input logic [15:0] exp);
	comparisons++;
	if (seen !== exp)
	begin
		error_cnt++;
		$display("wrong value at %0t: %h expected %h", $time, seen, exp);
	end
endtask
task cyc(input int n);
	repeat (n) @(posedge i_clk);
	#1;
endtask
task win(input int n);
	nfs = 0;
	nrx = 0;
	nsck = 0;
	ntx = 0;
	nso = 0;
	cyc(n);
endtask
task finish_test;
	$display("errors %0d comparisons %0d", error_cnt, comparisons);
	if (error_cnt == 0 && comparisons > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
initial
begin
	{i_resetn, i_module_on_bit, i_sync_direction_bit, i_tx_valid} = 4'h0;
	{i_bit_clock_direction_bit, m_ext, m_slv} = 3'h0;
	{i_word_length_field, i_frame_word_field} = 8'h31;
	i_sync_type_field = 2'h0;
	i_bit_rate_divisor = 12'h001;
	i_tx_data = 16'h1234;
	// divisor, sync type, word length, frame words
	cfg = '{12'h431, 12'h4f0, 12'h413, 12'h831, 12'h531, 12'h631, 12'h731};
	cyc(3);
	i_resetn = 1'b1;
	for (i = 0; i < 7; i++)
	begin
		i_module_on_bit = 1'b0;
		{i_bit_rate_divisor[1:0], i_sync_type_field, i_word_length_field,
			i_frame_word_field} = cfg[i];
		cyc(2);
		i_module_on_bit = 1'b1;
		cyc(40);
		w = 2 * (cfg[i][11:10] + 1) * (i_sync_type_field[1] ? 256 :
			(i_word_length_field + 1) * (i_frame_word_field + 1));
		win(4 * w);
		chk(nfs, 4);
		chk(nsck, 4 * w / (cfg[i][11:10] + 1));
		if (!i_sync_type_field[1]) chk(nrx, 4 * (i_frame_word_field + 1));
	end
	// link mode never drains, so the buffer fills up
	i_tx_valid = 1'b1;
	win(20);
	chk(ntx, 16);
	chk(o_tx_ready, 1'b0);
	i_tx_valid = 1'b0;
	i_module_on_bit = 1'b0;
	cyc(2);
	chk(o_tx_ready, 1'b1);
	{i_sync_type_field, i_word_length_field, i_frame_word_field} = 10'h031;
	{i_sync_direction_bit, m_slv} = 2'h3;
	cyc(2);
	i_module_on_bit = 1'b1;
	i_tx_valid = 1'b1;
	cyc(100);
	win(320);
	chk(nrx, 20);
	chk(nfs, 0);
	chk(nso, 20);
	chk({1'b0, o_rx_data[15:1] ^ o_rx_data[14:0]}, 16'h7fff);
	chk(o_frame_active, 1'b1);
	{i_module_on_bit, i_sync_direction_bit, m_slv} = 3'h0;
	i_bit_rate_divisor = 12'h000;
	{i_bit_clock_direction_bit, m_ext} = 2'h3;
	cyc(2);
	i_module_on_bit = 1'b1;
	cyc(100);
	win(800);
	chk(nfs, 10);
	chk(nsck, 0);
	{i_module_on_bit, i_bit_clock_direction_bit, m_ext} = 3'h0;
	i_bit_rate_divisor = 12'h001;
	cyc(4);
	win(40);
	chk(nsck, 20);
	finish_test;
end
endmodule

// [core/conv_defs.vh]
// constants for the converter serial frame timing core
// assumes inclusion by bare name from core/ design files
`ifndef CONV_DEFS_VH
`define CONV_DEFS_VH

// sync type field encodings
`define MODE_MULTI 2'h0
`define MODE_I2S 2'h1
`define MODE_AC16 2'h2
`define MODE_AC20 2'h3

// fixed slot geometry of the ac-link modes (last index values)
`define AC_SLOT16_LAST 5'h0f
`define AC_SLOT20_LAST 5'h13
`define AC16_WORDS_LAST 4'hf
`define AC20_WORDS_LAST 4'hc

`define DIV_ZERO 12'h000
`define WORD_W 16
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

// [core/converter_serial_frame_timing.v]
// timing core of a converter serial port: bit clock divider, word and
// frame counters, frame sync master/slave, tx fifo and rx shifter.
// assumes all non-clock inputs are synchronous to i_clk.
`timescale 1ns/10ps
`include "conv_defs.vh"

module tx_word_fifo #(
	parameter WIDTH = `WORD_W,
	parameter DEPTH = `FIFO_DEPTH,
	parameter AW = `FIFO_AW
)(
	input wire i_clk,
	input wire i_resetn,
	input wire i_clear,
	input wire [WIDTH-1:0] i_data,
	input wire i_valid,
	output wire o_ready,
	output wire [WIDTH-1:0] o_data,
	output wire o_valid,
	input wire i_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_reg;
	reg [AW-1:0] rd_reg;
	reg [AW:0] cnt_reg;
	wire push;
	wire pop;

	assign o_ready = (cnt_reg < DEPTH);
	assign o_valid = (cnt_reg != {(AW+1){1'b0}});
	assign o_data = mem[rd_reg];
	assign push = i_valid & o_ready;
	assign pop = o_valid & i_ready;

	always @(posedge i_clk)
	begin
		if (push)
			mem[wr_reg] <= i_data;
	end

	always @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end
		else if (i_clear)
		begin
			wr_reg <= {AW{1'b0}};
			rd_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			if (push & ~pop)
				cnt_reg <= cnt_reg + 1'b1;
			else if (pop & ~push)
				cnt_reg <= cnt_reg - 1'b1;
		end
	end
endmodule

module converter_serial_frame_timing #(
	parameter WIDTH = `WORD_W,
	parameter DEPTH = `FIFO_DEPTH,
	parameter AW = `FIFO_AW
)(
	input wire i_clk,
	input wire i_resetn,
	input wire i_module_on_bit,
	input wire [3:0] i_word_length_field,
	input wire [3:0] i_frame_word_field,
	input wire [1:0] i_sync_type_field,
	input wire i_sync_direction_bit,
	input wire [11:0] i_bit_rate_divisor,
	input wire i_bit_clock_direction_bit,
	input wire i_serial_bit_clock,
	output wire o_serial_bit_clock,
	output wire o_serial_bit_clock_oe,
	input wire i_frame_sync_pin,
	output wire o_frame_sync_pin,
	output wire o_frame_sync_pin_oe,
	output wire o_serial_out_pin,
	output wire o_serial_out_pin_oe,
	input wire i_serial_in_pin,
	input wire [WIDTH-1:0] i_tx_data,
	input wire i_tx_valid,
	output wire o_tx_ready,
	output wire [WIDTH-1:0] o_rx_data,
	output wire o_rx_valid,
	output wire o_frame_active
);
	reg [11:0] div_reg;
	reg sck_reg;
	reg sck_s1_reg;
	reg sck_s2_reg;
	reg sck_s3_reg;
	reg [4:0] bit_reg;
	reg [3:0] word_reg;
	reg busy_reg;
	reg fs_prev_reg;
	reg fs_out_reg;
	reg [WIDTH-1:0] tx_sh_reg;
	reg [WIDTH-1:0] rx_sh_reg;
	reg [WIDTH-1:0] rx_data_reg;
	reg rx_valid_reg;
	reg [4:0] bit_next;
	reg [3:0] word_next;
	reg busy_next;
	reg fs_calc;

	wire ext_clk;
	wire div_on;
	wire div_run;
	wire div_tick;
	wire rise;
	wire fall;
	wire master;
	wire is_ac;
	wire running;
	wire word_end;
	wire frame_end;
	wire slave_trig;
	wire [WIDTH-1:0] fifo_data;
	wire fifo_valid;
	wire fifo_pop;
	wire [3:0] half_words;

	// last bit index of the current slot
	function [4:0] slot_last;
		input [1:0] mode;
		input [3:0] ws;
		input [3:0] wcnt;
		begin
			case (mode)
				`MODE_AC16: slot_last = `AC_SLOT16_LAST;
				`MODE_AC20: slot_last = (wcnt == 4'h0) ?
					`AC_SLOT16_LAST : `AC_SLOT20_LAST;
				default: slot_last = {1'b0, ws};
			endcase
		end
	endfunction

	// last word index of the frame
	function [3:0] frame_last;
		input [1:0] mode;
		input [3:0] fsg;
		begin
			case (mode)
				`MODE_AC16: frame_last = `AC16_WORDS_LAST;
				`MODE_AC20: frame_last = `AC20_WORDS_LAST;
				default: frame_last = fsg;
			endcase
		end
	endfunction

	assign ext_clk = i_bit_clock_direction_bit;
	assign div_on = (i_bit_rate_divisor != `DIV_ZERO);
	// divider may run alone when it owns the clock pin
	assign div_run = div_on & (i_module_on_bit | ~ext_clk);
	assign div_tick = div_run & (div_reg >= i_bit_rate_divisor);

	always @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			div_reg <= 12'h000;
			sck_reg <= 1'b0;
		end
		else if (!div_run)
		begin
			div_reg <= 12'h000;
			sck_reg <= 1'b0;
		end
		else if (div_tick)
		begin
			div_reg <= 12'h000;
			sck_reg <= ~sck_reg;
		end
		else
			div_reg <= div_reg + 12'h001;
	end

	// external clock synchroniser; s1 feeds s2 only
	always @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sck_s1_reg <= 1'b0;
			sck_s2_reg <= 1'b0;
			sck_s3_reg <= 1'b0;
		end
		else
		begin
			sck_s1_reg <= i_serial_bit_clock;
			sck_s2_reg <= sck_s1_reg;
			sck_s3_reg <= sck_s2_reg;
		end
	end

	// no edges reach the counters while the module is off
	assign rise = i_module_on_bit & (ext_clk ?
		(sck_s2_reg & ~sck_s3_reg) : (div_tick & ~sck_reg));
	assign fall = i_module_on_bit & (ext_clk ?
		(~sck_s2_reg & sck_s3_reg) : (div_tick & sck_reg));

	assign master = ~i_sync_direction_bit;
	assign is_ac = i_sync_type_field[1];
	assign running = master | busy_reg;
	assign word_end = (bit_reg ==
		slot_last(i_sync_type_field, i_word_length_field, word_reg));
	assign frame_end = word_end & (word_reg ==
		frame_last(i_sync_type_field, i_frame_word_field));
	assign half_words = (i_frame_word_field >> 1) + 4'h1;

	// slave trigger sampled on the rising bit clock edge
	assign slave_trig = (i_sync_type_field == `MODE_I2S) ?
		(i_frame_sync_pin != fs_prev_reg) :
		(i_frame_sync_pin & (~busy_reg | frame_end));

	always @*
	begin
		bit_next = bit_reg;
		word_next = word_reg;
		busy_next = busy_reg;
		if (!master && slave_trig)
		begin
			// counters restart so bit 0 starts at this same rising edge
			bit_next = 5'h00;
			word_next = 4'h0;
			busy_next = 1'b1;
		end
		else if (running)
		begin
			if (word_end)
			begin
				bit_next = 5'h00;
				if (frame_end)
				begin
					word_next = 4'h0;
					busy_next = 1'b0;
				end
				else
					word_next = word_reg + 4'h1;
			end
			else
				bit_next = bit_reg + 5'h01;
		end
	end

	// master sync shape from the counters
	always @*
	begin
		case (i_sync_type_field)
			`MODE_MULTI: fs_calc = (word_reg == 4'h0) &&
				(bit_reg == 5'h00);
			`MODE_I2S: fs_calc = (word_reg < half_words);
			default: fs_calc = (word_reg == 4'h0);
		endcase
	end

	always @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			bit_reg <= 5'h00;
			word_reg <= 4'h0;
			busy_reg <= 1'b0;
			fs_prev_reg <= 1'b0;
		end
		else if (!i_module_on_bit)
		begin
			bit_reg <= 5'h00;
			word_reg <= 4'h0;
			busy_reg <= 1'b0;
			fs_prev_reg <= 1'b0;
		end
		else if (rise)
		begin
			bit_reg <= bit_next;
			word_reg <= word_next;
			busy_reg <= busy_next;
			fs_prev_reg <= i_frame_sync_pin;
		end
	end

	always @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			fs_out_reg <= 1'b0;
		else
			fs_out_reg <= i_module_on_bit & master & fs_calc;
	end

	// word loaded at slot start, popped from the fifo when present, but never popped in the ac-link modes
	assign fifo_pop = rise & running & word_end & ~is_ac;

	always @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			tx_sh_reg <= {WIDTH{1'b0}};
		else if (!i_module_on_bit)
			tx_sh_reg <= {WIDTH{1'b0}};
		else if (rise && running)
		begin
			if (word_end)
				tx_sh_reg <= fifo_valid ? fifo_data : {WIDTH{1'b0}};
			else
				tx_sh_reg <= {tx_sh_reg[WIDTH-2:0], 1'b0};
		end
	end

	always @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rx_sh_reg <= {WIDTH{1'b0}};
			rx_data_reg <= {WIDTH{1'b0}};
			rx_valid_reg <= 1'b0;
		end
		else
		begin
			rx_valid_reg <= 1'b0;
			if (!i_module_on_bit)
				rx_sh_reg <= {WIDTH{1'b0}};
			else if (fall && running)
			begin
				rx_sh_reg <= {rx_sh_reg[WIDTH-2:0], i_serial_in_pin};
				if (word_end)
				begin
					rx_data_reg <= {rx_sh_reg[WIDTH-2:0],
						i_serial_in_pin};
					rx_valid_reg <= 1'b1;
				end
			end
		end
	end

	tx_word_fifo #(
		.WIDTH(WIDTH),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_fifo (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_clear(~i_module_on_bit),
		.i_data(i_tx_data),
		.i_valid(i_tx_valid),
		.o_ready(o_tx_ready),
		.o_data(fifo_data),
		.o_valid(fifo_valid),
		.i_ready(fifo_pop)
	);

	assign o_serial_bit_clock = sck_reg;
	assign o_serial_bit_clock_oe = ~ext_clk & div_run;
	assign o_frame_sync_pin = fs_out_reg;
	assign o_frame_sync_pin_oe = i_module_on_bit & master;
	assign o_serial_out_pin = tx_sh_reg[WIDTH-1];
	assign o_serial_out_pin_oe = i_module_on_bit;
	assign o_rx_data = rx_data_reg;
	assign o_rx_valid = rx_valid_reg;
	assign o_frame_active = running & i_module_on_bit;
endmodule
